// >>> rtl/swpl_pkg.sv
// What this block does
// [RULE_01] Two-channel word: nine bits, channel-select bit first, then data MSB first.
// [RULE_02] Single-channel word: eight data bits, MSB first.
// [RULE_03] Channel-select 0 loads the first wiper latch, 1 loads the second.
// [RULE_04] With chip select low, each serial clock rise shifts one input bit in.
// [RULE_05] Each shift puts the bit entered eight shifts earlier on the chain output.
// [RULE_06] Chip select low, clock low: shift register holds, chain output driver enabled.
// [RULE_07] Chip select rise, preset and power-down inactive: shift register loads wiper latch.
// [RULE_08] Two-channel: only the last nine bits shifted are kept; earlier ones dropped.
// [RULE_09] Chip select rise decodes channel bit, loads exactly one latch with eight data bits.
// [RULE_10] Controller sends two separate framed words to change both channels.
// [RULE_11] Preset low forces all latches to 0x80 and clears the chain output latch.
// [RULE_12] Preset rise with chip select high and power-down inactive latches 0x80 everywhere.
// [RULE_13] Power-up presets every wiper latch to mid-scale.
// [RULE_14] Power-down low opens top ends, joins wiper to bottom, turns chain output off.
// [RULE_15] Power-down keeps wiper latch contents for return to operation.
// [RULE_16] Chain output only pulls low; an external pull-up makes the high level.
// [RULE_17] Two chained single devices: sixteen bits, far byte first, one chip select rise.
// [RULE_18] Controller should lengthen serial clock period when daisy-chaining.
// [RULE_19] Each channel decodes its code to one of 256 taps, exactly one closed.
// [RULE_20] Chip select high with preset and power-down inactive: clock has no effect.
// [RULE_21] First channel value drives first wiper output, second value the second.
// [RULE_22] Preset low during a chip select rise wins; latches end at mid-scale.
package swpl_pkg;
    localparam int DATA_BITS = 8;
    localparam int WORD_BITS = 9;
    localparam int CHSEL_POS = 8;
    localparam int CHAIN_TAP_POS = 7;
    localparam int TAP_COUNT = 256;
    localparam int CHANNELS = 2;
    localparam logic [7:0] MIDSCALE_CODE = 8'h80;
    localparam logic [8:0] SHIFT_RESET = 9'h000;
    localparam logic CHAIN_BIT_RESET = 1'b0;
    localparam logic CS_IDLE = 1'b1;
    localparam logic PIN_INACTIVE = 1'b1;
    localparam logic CHSEL_FIRST = 1'b0;
    localparam logic CHSEL_SECOND = 1'b1;
    localparam logic [255:0] TAP_ONE = 256'h1;
    localparam logic [255:0] TAP_MIDSCALE = TAP_ONE << MIDSCALE_CODE;

    typedef enum logic [1:0] {
        ACT_NONE,
        ACT_MIDSCALE,
        ACT_LOAD
    } swpl_act_t;
endpackage

// >>> rtl/swpl_tap_decode.sv
`timescale 1ns/1ps
module swpl_tap_decode
    import swpl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Latch code in, one-hot tap switches out
    input wire logic [DATA_BITS-1:0] code,
    output logic [TAP_COUNT-1:0] tap_r
);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tap_r <= TAP_MIDSCALE;
        end else begin
            tap_r <= TAP_ONE << code; // RULE_19
        end
    end

    tap_onehot_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_19
        $onehot(tap_r) && (tap_r == (TAP_ONE << $past(code))) || $past(!rst_n))
        else $error("tap switches not one-hot on latch code");

endmodule

// >>> rtl/swpl_top.sv
`timescale 1ns/1ps
module swpl_top
    import swpl_pkg::*;
#(
    parameter bit DUAL_CHANNEL = 1'b1
) (
    // System clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Serial link
    input wire logic LINK_CLK,
    input wire logic CS_N,
    input wire logic SERIAL_IN,
    // Open-drain chain output
    input wire logic CHAIN_OUT_I,
    output logic CHAIN_OUT_O,
    output logic CHAIN_OUT_OE_N,
    // Control pins
    input wire logic MIDSCALE_PRESET_N,
    input wire logic POWER_DOWN_N,
    // Wiper latches and tap switches
    output logic [DATA_BITS-1:0] WIPER_LATCH_0,
    output logic [DATA_BITS-1:0] WIPER_LATCH_1,
    output logic [TAP_COUNT-1:0] TAP_SEL_0,
    output logic [TAP_COUNT-1:0] TAP_SEL_1,
    // End terminal switches
    output logic [CHANNELS-1:0] TOP_END_SWITCH_ON,
    output logic [CHANNELS-1:0] WIPER_TO_BOTTOM,
    // Status
    output logic UPDATE_DONE,
    output logic CHAIN_LEVEL
);

    ////////////////////////////////////////////////////////////////////////////////
    // Link clock domain

    logic [WORD_BITS-1:0] shift_reg_r;
    logic chain_bit_r;
    logic chain_rst_n;

    // Preset clears the chain output latch even while the link clock is stopped
    assign chain_rst_n = RST_N & MIDSCALE_PRESET_N;

    // Only the newest nine bits survive; surplus leading bits fall off the top
    always_ff @(posedge LINK_CLK or negedge RST_N) begin
        if (!RST_N) begin
            shift_reg_r <= SHIFT_RESET;
        end else if (!CS_N) begin
            shift_reg_r <= {shift_reg_r[WORD_BITS-2:0], SERIAL_IN}; // RULE_04 RULE_08 RULE_01 RULE_02
        end
    end

    always_ff @(posedge LINK_CLK or negedge chain_rst_n) begin
        if (!chain_rst_n) begin
            chain_bit_r <= CHAIN_BIT_RESET; // RULE_11
        end else if (!CS_N) begin
            chain_bit_r <= shift_reg_r[CHAIN_TAP_POS]; // RULE_05
        end
    end

    // Checker helper: run of consecutive selected shifts, saturating at eight
    logic [3:0] sel_run_r;

    always_ff @(posedge LINK_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sel_run_r <= 4'h0;
        end else if (CS_N) begin
            sel_run_r <= 4'h0;
        end else if (sel_run_r != 4'(DATA_BITS)) begin
            sel_run_r <= sel_run_r + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Synchronisers into the system clock domain

    logic cs_meta_r;
    logic cs_sync_r;
    logic cs_prev_r;
    logic pr_meta_r;
    logic pr_sync_r;
    logic pr_prev_r;
    logic pd_meta_r;
    logic pd_sync_r;
    logic chain_meta_r;
    logic chain_sync_r;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cs_meta_r <= CS_IDLE;
            cs_sync_r <= CS_IDLE;
            cs_prev_r <= CS_IDLE;
        end else begin
            cs_meta_r <= CS_N;
            cs_sync_r <= cs_meta_r;
            cs_prev_r <= cs_sync_r;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pr_meta_r <= PIN_INACTIVE;
            pr_sync_r <= PIN_INACTIVE;
            pr_prev_r <= PIN_INACTIVE;
        end else begin
            pr_meta_r <= MIDSCALE_PRESET_N;
            pr_sync_r <= pr_meta_r;
            pr_prev_r <= pr_sync_r;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pd_meta_r <= PIN_INACTIVE;
            pd_sync_r <= PIN_INACTIVE;
        end else begin
            pd_meta_r <= POWER_DOWN_N;
            pd_sync_r <= pd_meta_r;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            chain_meta_r <= CHAIN_BIT_RESET;
            chain_sync_r <= CHAIN_BIT_RESET;
        end else begin
            chain_meta_r <= chain_bit_r;
            chain_sync_r <= chain_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Load decision

    logic cs_rise;
    logic pr_rise;
    logic load_ch;
    logic [DATA_BITS-1:0] load_data;
    swpl_act_t act;

    assign cs_rise = cs_sync_r & ~cs_prev_r;
    assign pr_rise = pr_sync_r & ~pr_prev_r;

    // The shift register is frozen while chip select is high, so the word is
    // stable by the time the synchronised rising edge is seen here
    assign load_ch = DUAL_CHANNEL ? shift_reg_r[CHSEL_POS] : CHSEL_FIRST; // RULE_09
    assign load_data = shift_reg_r[DATA_BITS-1:0]; // RULE_09

    always_comb begin
        act = ACT_NONE;
        if (!pr_sync_r) begin
            act = ACT_MIDSCALE; // RULE_11 RULE_22
        end else if (pr_rise && cs_sync_r && pd_sync_r) begin
            act = ACT_MIDSCALE; // RULE_12
        end else if (cs_rise && pd_sync_r) begin
            act = ACT_LOAD; // RULE_07 RULE_15 RULE_20
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Wiper latches

    logic [DATA_BITS-1:0] wiper0_r;
    logic [DATA_BITS-1:0] wiper1_r;
    logic update_done_r;

    // Power-down leaves the latches alone
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wiper0_r <= MIDSCALE_CODE; // RULE_13
            wiper1_r <= MIDSCALE_CODE; // RULE_13
        end else begin
            case (act)
                ACT_MIDSCALE: begin
                    wiper0_r <= MIDSCALE_CODE; // RULE_11 RULE_12
                    wiper1_r <= MIDSCALE_CODE;
                end
                ACT_LOAD: begin
                    if (load_ch == CHSEL_FIRST) begin
                        wiper0_r <= load_data; // RULE_03 RULE_21
                    end else begin
                        wiper1_r <= load_data; // RULE_03 RULE_21
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            update_done_r <= 1'b0;
        end else begin
            update_done_r <= (act == ACT_LOAD);
        end
    end

    assign WIPER_LATCH_0 = wiper0_r;
    assign WIPER_LATCH_1 = wiper1_r;
    assign UPDATE_DONE = update_done_r;

    swpl_tap_decode u_tap0 (
        .clk(CLK),
        .rst_n(RST_N),
        .code(wiper0_r),
        .tap_r(TAP_SEL_0)
    );

    swpl_tap_decode u_tap1 (
        .clk(CLK),
        .rst_n(RST_N),
        .code(wiper1_r),
        .tap_r(TAP_SEL_1)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // End switches and chain output

    logic [CHANNELS-1:0] top_on_r;
    logic [CHANNELS-1:0] to_bottom_r;
    logic chain_oe_n_r;
    logic chain_level_r;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            top_on_r <= {CHANNELS{1'b1}};
            to_bottom_r <= {CHANNELS{1'b0}};
        end else begin
            top_on_r <= {CHANNELS{pd_sync_r}}; // RULE_14
            to_bottom_r <= {CHANNELS{~pd_sync_r}}; // RULE_14
        end
    end

    // Pull-down only: the pin is driven solely to send a zero
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            chain_oe_n_r <= 1'b1;
        end else begin
            chain_oe_n_r <= ~(~cs_sync_r & pd_sync_r & ~chain_sync_r); // RULE_06 RULE_14 RULE_16
        end
    end

    logic chain_lvl_meta_r;

    // Level seen on the wire, synchronised, for status only
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            chain_lvl_meta_r <= 1'b1;
            chain_level_r <= 1'b1;
        end else begin
            chain_lvl_meta_r <= CHAIN_OUT_I;
            chain_level_r <= chain_lvl_meta_r;
        end
    end

    assign CHAIN_OUT_O = 1'b0; // RULE_16
    assign CHAIN_OUT_OE_N = chain_oe_n_r;
    assign TOP_END_SWITCH_ON = top_on_r;
    assign WIPER_TO_BOTTOM = to_bottom_r;
    assign CHAIN_LEVEL = chain_level_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks in the link domain

    shift_in_a: assert property (@(posedge LINK_CLK) disable iff (!RST_N) // RULE_04
        !CS_N |=> shift_reg_r == {$past(shift_reg_r[WORD_BITS-2:0]), $past(SERIAL_IN)})
        else $error("serial bit not shifted in while selected");

    shift_hold_a: assert property (@(posedge LINK_CLK) disable iff (!RST_N) // RULE_20
        CS_N |=> shift_reg_r == $past(shift_reg_r))
        else $error("shift register moved while deselected");

    chain_delay_a: assert property (@(posedge LINK_CLK) disable iff (!chain_rst_n) // RULE_05
        !CS_N && sel_run_r == 4'(DATA_BITS) |=> chain_bit_r == $past(SERIAL_IN, 9))
        else $error("chain output not eight shifts behind input");

    ////////////////////////////////////////////////////////////////////////////////
    // Checks in the system domain

    preset_force_a: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_11
        !pr_sync_r |=> wiper0_r == MIDSCALE_CODE && wiper1_r == MIDSCALE_CODE)
        else $error("preset did not force mid-scale");

    preset_wins_a: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_22
        cs_rise && !pr_sync_r |=> !update_done_r && wiper0_r == MIDSCALE_CODE)
        else $error("load beat an active preset");

    preset_rise_a: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_12
        pr_rise && cs_sync_r && pd_sync_r |=> wiper0_r == MIDSCALE_CODE && wiper1_r == MIDSCALE_CODE)
        else $error("preset release did not latch mid-scale");

    load_first_a: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_03
        cs_rise && pr_sync_r && pd_sync_r && load_ch == CHSEL_FIRST
        |=> wiper0_r == $past(load_data) && $stable(wiper1_r) && update_done_r)
        else $error("first channel load wrong");

    load_second_a: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_21
        cs_rise && pr_sync_r && pd_sync_r && load_ch == CHSEL_SECOND
        |=> wiper1_r == $past(load_data) && $stable(wiper0_r))
        else $error("second channel load wrong");

    shutdown_keep_a: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_15
        !pd_sync_r && pr_sync_r |=> $stable(wiper0_r) && $stable(wiper1_r))
        else $error("latch changed during power-down");

    chain_off_a: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_14
        !pd_sync_r |=> chain_oe_n_r && top_on_r == {CHANNELS{1'b0}}
        && to_bottom_r == {CHANNELS{1'b1}})
        else $error("power-down did not release terminals");

    chain_drive_a: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_06
        !cs_sync_r && pd_sync_r && !chain_sync_r |=> !chain_oe_n_r)
        else $error("chain output not driven while selected");

endmodule

// >>> verif/swpl_host.sv
`timescale 1ns/1ps
module swpl_host (
    // Link pins toward the block
    output logic link_clk,
    output logic cs_n,
    output logic serial_in,
    // Chain pin level after the pull-up
    input wire logic chain_wire
);
    logic [15:0] seen;

    initial begin
        link_clk = 1'b0;
        cs_n = 1'b1;
        serial_in = 1'b0;
        seen = 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////
    // One framed word, MSB first; clock stands still outside the frame
    task automatic send(input logic [15:0] w, input int n, input int half);
        // Start off the system clock's edges so the two clocks stay unrelated
        #1.3;
        cs_n = 1'b0;
        #(half);
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = w[i];
            #(half);
            link_clk = 1'b1;
            #(half);
            link_clk = 1'b0;
            seen = {seen[14:0], chain_wire};
        end
        cs_n = 1'b1;
        // No pull on the data line, so it must not keep its last level
        serial_in = ~serial_in;
        #(4 * half);
    endtask

    // Clock pulses with chip select high; the block must ignore them
    task automatic idle_clocks(input int n, input int half);
        for (int i = 0; i < n; i++) begin
            serial_in = 1'b1;
            #(half);
            link_clk = 1'b1;
            #(half);
            link_clk = 1'b0;
        end
    endtask
endmodule

// >>> verif/tb.sv
`timescale 1ns/1ps
module tb;
    import swpl_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic preset_n = 1'b1;
    logic pdown_n = 1'b1;
    wire link_clk;
    wire cs_n;
    wire ser;
    wire chain_wire;
    logic chain_o, oe_n, done, lvl;
    logic [DATA_BITS-1:0] lat0, lat1, e0, e1;
    logic [DATA_BITS-1:0] s_lat0, s_lat1, s0;
    logic [TAP_COUNT-1:0] tap0, tap1;
    logic [CHANNELS-1:0] top_on, to_bot;
    logic [8:0] words [5];
    int err_total = 0;
    int num_checks = 0;
    int done_cnt = 0;
    int n0;

    always #2.5 clk = ~clk;

    // Pull-up on the open-drain chain pin
    assign chain_wire = oe_n ? 1'b1 : chain_o;

    always @(posedge clk) if (done === 1'b1) done_cnt <= done_cnt + 1;

    swpl_top #(.DUAL_CHANNEL(1'b1)) dut (
        .CLK(clk), .RST_N(rst_n), .LINK_CLK(link_clk), .CS_N(cs_n),
        .SERIAL_IN(ser), .CHAIN_OUT_I(chain_wire), .CHAIN_OUT_O(chain_o),
        .CHAIN_OUT_OE_N(oe_n), .MIDSCALE_PRESET_N(preset_n),
        .POWER_DOWN_N(pdown_n), .WIPER_LATCH_0(lat0), .WIPER_LATCH_1(lat1),
        .TAP_SEL_0(tap0), .TAP_SEL_1(tap1), .TOP_END_SWITCH_ON(top_on),
        .WIPER_TO_BOTTOM(to_bot), .UPDATE_DONE(done), .CHAIN_LEVEL(lvl)
    );

    // Single-channel variant on the same link; it loads the last eight bits
    swpl_top #(.DUAL_CHANNEL(1'b0)) dut_single (
        .CLK(clk), .RST_N(rst_n), .LINK_CLK(link_clk), .CS_N(cs_n),
        .SERIAL_IN(ser), .CHAIN_OUT_I(1'b1), .CHAIN_OUT_O(),
        .CHAIN_OUT_OE_N(), .MIDSCALE_PRESET_N(preset_n),
        .POWER_DOWN_N(pdown_n), .WIPER_LATCH_0(s_lat0), .WIPER_LATCH_1(s_lat1),
        .TAP_SEL_0(), .TAP_SEL_1(), .TOP_END_SWITCH_ON(),
        .WIPER_TO_BOTTOM(), .UPDATE_DONE(), .CHAIN_LEVEL()
    );

    swpl_host host (.link_clk(link_clk), .cs_n(cs_n), .serial_in(ser),
        .chain_wire(chain_wire));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [255:0] got, input logic [255:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic chk_lat();
        chk(256'(lat0), 256'(e0));
        chk(256'(lat1), 256'(e1));
        chk(tap0, TAP_ONE << e0);
        chk(tap1, TAP_ONE << e1);
        chk(256'(s_lat0), 256'(s0));
        chk(256'(s_lat1), 256'(MIDSCALE_CODE));
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        words = '{9'h000, 9'h1ff, 9'h05a, 9'h1a5, 9'h0c4};
        e0 = MIDSCALE_CODE;
        e1 = MIDSCALE_CODE;
        s0 = MIDSCALE_CODE;
        cycles(20);
        rst_n <= 1'b1;
        cycles(4);
        chk_lat();
        chk(256'(top_on), 256'(2'b11));
        chk(256'(to_bot), 256'(2'b00));
        chk(256'(oe_n), 256'(1'b1));
        chk(256'(chain_o), 256'(1'b0));
        chk(256'(lvl), 256'(1'b1));
        $display("Reset values test done");

        // Both channels, boundary and mixed codes
        foreach (words[i]) begin
            n0 = done_cnt;
            host.send({7'h00, words[i]}, 9, 40);
            if (words[i][8]) e1 = words[i][7:0];
            else e0 = words[i][7:0];
            s0 = words[i][7:0];
            chk(256'(done_cnt - n0), 256'd1);
            chk_lat();
        end
        $display("Single word load test done");

        // Sixteen bits in one frame: surplus dropped, first byte passed on
        n0 = done_cnt;
        host.send(16'h3de1, 16, 80);
        e1 = 8'he1;
        s0 = 8'he1;
        chk(256'(host.seen[7:0]), 256'(8'h3d));
        chk(256'(done_cnt - n0), 256'd1);
        chk_lat();
        $display("Chained frame test done");

        // Clock pulses while deselected leave the shift register alone
        host.send(16'h003c, 9, 40);
        e0 = 8'h3c;
        s0 = 8'h3c;
        host.idle_clocks(4, 40);
        n0 = done_cnt;
        host.send(16'h0000, 0, 40);
        chk(256'(done_cnt - n0), 256'd1);
        chk_lat();
        $display("Deselected clock test done");

        // Power-down: ends switched, chain released, load refused
        @(posedge clk) pdown_n <= 1'b0;
        cycles(6);
        chk(256'(top_on), 256'(2'b00));
        chk(256'(to_bot), 256'(2'b11));
        n0 = done_cnt;
        host.send(16'h0033, 9, 40);
        chk(256'(host.seen[8:0]), 256'(9'h1ff));
        chk(256'(done_cnt - n0), 256'd0);
        chk_lat();
        @(posedge clk) pdown_n <= 1'b1;
        cycles(6);
        chk(256'(top_on), 256'(2'b11));
        chk(256'(to_bot), 256'(2'b00));
        chk_lat();
        $display("Power-down test done");

        // Preset low wins over a frame; chain bit held cleared
        @(posedge clk) preset_n <= 1'b0;
        cycles(6);
        e0 = MIDSCALE_CODE;
        e1 = MIDSCALE_CODE;
        s0 = MIDSCALE_CODE;
        chk_lat();
        host.send(16'h0177, 9, 40);
        chk(256'(host.seen[8:0]), 256'(9'h000));
        chk_lat();
        @(posedge clk) preset_n <= 1'b1;
        cycles(6);
        chk_lat();
        n0 = done_cnt;
        host.send(16'h0011, 9, 40);
        e0 = 8'h11;
        s0 = 8'h11;
        chk(256'(done_cnt - n0), 256'd1);
        chk_lat();
        $display("Preset test done");
        give_verdict();
    end

    initial begin
        #60000;
        err_total++;
        give_verdict();
    end
endmodule
